/* File: hw/mptf_top.sv */
// In-band management port framer: CPU-bound tagging, host frame parsing and
// steering, register access at the documented offsets.
// Assumes the switch core supplies frame class and ingress port, and the
// media interface logic presents bytes on sys_clk.
`timescale 1ns/1ps
module mptf_top
   import mptf_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic sw_valid,
   input wire logic [7:0] sw_data,
   input wire logic sw_last,
   input wire logic sw_first,
   input wire logic [1:0] sw_class,
   input wire logic sw_mirror,
   input wire logic [4:0] sw_src_port,
   input wire logic [13:0] sw_len,
   output logic sw_ready,
   output logic cpu_tx_valid,
   output logic [7:0] cpu_tx_data,
   output logic cpu_tx_last,
   input wire logic cpu_rx_valid,
   input wire logic [7:0] cpu_rx_data,
   input wire logic cpu_rx_last,
   input wire logic [47:0] arl_dest_map,
   input wire logic [16:0] bcast_rule_map,
   output logic host_valid,
   output logic [7:0] host_data,
   output logic host_last,
   output logic host_done,
   output logic host_drop,
   output logic [1:0] host_fwd_kind,
   output logic [16:0] host_fwd_map,
   output logic [1:0] speed_mode,
   output logic port_attached
);
   // ==========================================
   // Registers
   logic [7:0] ctrl_r;
   logic [7:0] mode_r;
   logic [7:0] cfg_r;
   logic [15:0] frames_r;
   logic admit_r;
   logic [7:0] rd_nxt;

   wire attached_w = cfg_r[MPTF_POS_PORT_SEL +: 2] == MPTF_PORT_SEL_MII;
   wire active_w = attached_w && mode_r[MPTF_BIT_MGMT_MODE];
   wire class_en_w = (sw_class == 2'h0 && ctrl_r[MPTF_BIT_UCST_EN])
      || (sw_class == 2'h1 && ctrl_r[MPTF_BIT_MCST_EN])
      || (sw_class == 2'h2 && ctrl_r[MPTF_BIT_BCST_EN]);
   wire admit_now_w = active_w && (class_en_w || sw_mirror);

   always_comb begin
      unique case (reg_addr)
         MPTF_ADDR_MGMT_PORT_CONTROL: rd_nxt = ctrl_r;
         MPTF_ADDR_SWITCH_OPERATING_MODE: rd_nxt = mode_r;
         MPTF_ADDR_MGMT_CONFIG: rd_nxt = cfg_r;
         MPTF_ADDR_STATUS: rd_nxt = frames_r[7:0];
         default: rd_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctrl_r <= MPTF_RST_CTRL;
         mode_r <= MPTF_RST_MODE;
         cfg_r <= MPTF_RST_CFG;
         reg_rdata <= 8'h00;
      end else begin
         if (reg_wr && reg_addr == MPTF_ADDR_MGMT_PORT_CONTROL) ctrl_r <= reg_wdata;
         if (reg_wr && reg_addr == MPTF_ADDR_SWITCH_OPERATING_MODE) mode_r <= reg_wdata;
         if (reg_wr && reg_addr == MPTF_ADDR_MGMT_CONFIG) cfg_r <= reg_wdata;
         if (reg_rd) reg_rdata <= rd_nxt;
      end
   end

   // ==========================================
   // Toward the CPU
   // Admission is decided on the first byte and held for the frame, so a
   // register write mid-frame never cuts a frame in half.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         admit_r <= 1'b0;
      end else if (sw_valid && sw_first) begin
         admit_r <= admit_now_w;
      end
   end
   wire admit_w = sw_first ? admit_now_w : admit_r;
   logic tg_ready;
   logic tg_valid;
   logic [7:0] tg_data;
   logic tg_last;
   assign sw_ready = tg_ready || !admit_w; // Rejected frames are sunk

   mptf_tx_tagger u_tagger (
      .sys_clk(sys_clk),
      .rst(rst),
      .in_valid(sw_valid && admit_w && tg_ready),
      .in_data(sw_data),
      .in_last(sw_last),
      .in_src_port(sw_src_port),
      .in_len(sw_len),
      .in_ready(tg_ready),
      .out_valid(tg_valid),
      .out_data(tg_data),
      .out_last(tg_last)
   );

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cpu_tx_valid <= 1'b0;
         cpu_tx_data <= 8'h00;
         cpu_tx_last <= 1'b0;
         frames_r <= 16'h0000;
      end else begin
         cpu_tx_valid <= tg_valid;
         cpu_tx_data <= tg_data;
         cpu_tx_last <= tg_last;
         if (tg_valid && tg_last) frames_r <= frames_r + 16'h0001;
      end
   end

   // ==========================================
   // From the host
   logic pr_valid;
   logic [7:0] pr_data;
   logic pr_last;
   logic pr_done;
   logic pr_drop;
   logic [31:0] pr_tag;

   mptf_rx_parser u_parser (
      .sys_clk(sys_clk),
      .rst(rst),
      .in_valid(cpu_rx_valid && active_w),
      .in_data(cpu_rx_data),
      .in_last(cpu_rx_last),
      .out_valid(pr_valid),
      .out_data(pr_data),
      .out_last(pr_last),
      .done(pr_done),
      .drop(pr_drop),
      .tag(pr_tag)
   );

   wire [2:0] op_w = pr_tag[31:29];
   wire bcast_w = arl_dest_map == 48'hFFFFFFFFFFFF;
   wire [16:0] single_w = 17'h00001 << pr_tag[4:0];
   logic [1:0] kind_nxt;
   logic [16:0] map_nxt;

   always_comb begin
      kind_nxt = MPTF_FWD_ARL;
      map_nxt = 17'h00000;
      if (op_w == MPTF_OP_SINGLE) begin
         kind_nxt = MPTF_FWD_MAP;
         map_nxt = single_w;
      end else if (op_w == MPTF_OP_MULTI) begin
         kind_nxt = MPTF_FWD_MAP;
         map_nxt = pr_tag[16:0];
      end else if (bcast_w) begin
         kind_nxt = MPTF_FWD_BCAST;
         map_nxt = bcast_rule_map;
      end else begin
         kind_nxt = MPTF_FWD_ARL;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         host_valid <= 1'b0;
         host_data <= 8'h00;
         host_last <= 1'b0;
         host_done <= 1'b0;
         host_drop <= 1'b0;
         host_fwd_kind <= 2'h0;
         host_fwd_map <= 17'h00000;
         speed_mode <= 2'h0;
         port_attached <= 1'b0;
      end else begin
         host_valid <= pr_valid;
         host_data <= pr_data;
         host_last <= pr_last;
         host_done <= pr_done;
         host_drop <= pr_done && pr_drop;
         if (pr_done) begin
            host_fwd_kind <= kind_nxt;
            host_fwd_map <= map_nxt;
         end
         speed_mode <= cfg_r[1:0];
         port_attached <= active_w;
      end
   end

   // ==========================================
   // Checks
   property p_drop_reserved;
      @(posedge sys_clk) disable iff (rst)
      pr_done && (op_w == 3'h1 || op_w[2]) |=> host_done && host_drop;
   endproperty
   a_drop_reserved: assert property (p_drop_reserved) else $error("reserved opcode kept");

   property p_single_port;
      @(posedge sys_clk) disable iff (rst)
      pr_done && op_w == 3'h2 |=> host_fwd_map == (17'h00001 << $past(pr_tag[4:0]));
   endproperty
   a_single_port: assert property (p_single_port) else $error("single port map wrong");

   property p_multi_map;
      @(posedge sys_clk) disable iff (rst)
      pr_done && op_w == 3'h3 |=> host_fwd_map == $past(pr_tag[16:0]);
   endproperty
   a_multi_map: assert property (p_multi_map) else $error("forward map wrong");

   property p_bcast_rule;
      @(posedge sys_clk) disable iff (rst)
      pr_done && op_w == 3'h0 && bcast_w |=> host_fwd_kind == 2'(MPTF_FWD_BCAST);
   endproperty
   a_bcast_rule: assert property (p_bcast_rule) else $error("broadcast rule ignored");

   property p_arl;
      @(posedge sys_clk) disable iff (rst)
      pr_done && op_w == 3'h0 && !bcast_w |=> host_fwd_kind == 2'(MPTF_FWD_ARL);
   endproperty
   a_arl: assert property (p_arl) else $error("lookup not used");

   property p_class_gate;
      @(posedge sys_clk) disable iff (rst)
      sw_valid && sw_first && !sw_mirror && !class_en_w |=> !cpu_tx_valid ##1 !cpu_tx_valid;
   endproperty
   a_class_gate: assert property (p_class_gate) else $error("disabled class forwarded");

   property p_off_no_tx;
      @(posedge sys_clk) disable iff (rst)
      !active_w [*3] |-> !cpu_tx_valid;
   endproperty
   a_off_no_tx: assert property (p_off_no_tx) else $error("traffic while detached");

   property p_frame_end_fcs;
      @(posedge sys_clk) disable iff (rst)
      cpu_tx_valid && cpu_tx_last |-> $past(cpu_tx_valid, 1) && $past(cpu_tx_valid, 3);
   endproperty
   a_frame_end_fcs: assert property (p_frame_end_fcs) else $error("fcs bytes missing");
endmodule

/* File: hw/mptf_pkg.sv */
// Constants, types and register layout shared by the management tag framer.
// Assumes one 20 MHz system clock and a byte-wide internal frame stream.
//
// Functional notes
// - Frame classes reach the management port only when their enable bit is set or the frame is mirrored (sw_mirror).
// - Toward the CPU a type field and 32-bit tag follow the source address.
// - The inserted type field is 8874h, directly ahead of the tag.
// - A fresh FCS over the modified frame is appended toward the CPU.
// - The outgoing tag names the ingress port of the original frame.
// - Host tag opcode picks address lookup or tag-named destination.
// - Type and tag travel most significant octet first.
// - With management mode on, every port frame carries the 4-byte tag.
// - The management port never carries untagged data traffic.
// - Opcode 000 unicast or multicast frames use address table lookup.
// - Opcode 000 broadcast frames follow the broadcast rule in effect.
// - Opcode 010 frames go only to the port in tag bits 4:0.
// - Opcode 011 frames go to ports set in tag bits 16:0.
// - The port runs full duplex at 10, 100 and 1000 Mbps.
// - The framer attaches to the port only when the select field chooses it.
// - Gigabit interface data moves on rising edges only.
// - Reduced gigabit interface data moves on both edges, 4 bits wide.
// - Reverse media interface runs 10 Mbps, full and half duplex.
// - Host frames with opcode 001 or 1xx are dropped.
// - Host opcode is tag 31:29, port id 4:0, forward map 16:0.
// - Host frames are at least 74 bytes; type, tag and outer CRC stripped.
// - CPU tags use opcode 000, byte count 28:15, source port 4:0.
package mptf_pkg;
   // ==========================================
   // Register map
   localparam logic [7:0] MPTF_ADDR_MGMT_PORT_CONTROL = 8'h10;
   localparam logic [7:0] MPTF_ADDR_SWITCH_OPERATING_MODE = 8'h20;
   localparam logic [7:0] MPTF_ADDR_MGMT_CONFIG = 8'h30;
   localparam logic [7:0] MPTF_ADDR_STATUS = 8'h31;
   localparam int MPTF_BIT_UCST_EN = 4;
   localparam int MPTF_BIT_MCST_EN = 3;
   localparam int MPTF_BIT_BCST_EN = 2;
   localparam int MPTF_BIT_MGMT_MODE = 1;
   localparam int MPTF_POS_PORT_SEL = 6;
   localparam logic [1:0] MPTF_PORT_SEL_MII = 2'h2;
   localparam logic [7:0] MPTF_RST_CTRL = 8'h00;
   localparam logic [7:0] MPTF_RST_MODE = 8'h00;
   localparam logic [7:0] MPTF_RST_CFG = 8'h00;
   // ==========================================
   // Tag layout
   localparam logic [15:0] MPTF_MGMT_TYPE = 16'h8874;
   localparam logic [2:0] MPTF_OP_NORMAL = 3'h0;
   localparam logic [2:0] MPTF_OP_SINGLE = 3'h2;
   localparam logic [2:0] MPTF_OP_MULTI = 3'h3;
   localparam int MPTF_TAG_OP_LSB = 29;
   localparam int MPTF_TAG_CNT_LSB = 15;
   localparam int MPTF_HDR_BYTES = 6;
   localparam int MPTF_SA_END = 12;
   localparam logic [13:0] MPTF_MIN_HOST_LEN = 14'h004A;
   localparam logic [31:0] MPTF_CRC_INIT = 32'hFFFFFFFF;
   localparam logic [31:0] MPTF_CRC_POLY = 32'hEDB88320;
   localparam int MPTF_NPORTS = 17;

   typedef enum logic [1:0] {
      MPTF_FWD_ARL,
      MPTF_FWD_BCAST,
      MPTF_FWD_MAP
   } mptf_fwd_t;

   function automatic logic [31:0] mptf_crc_byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {24'h000000, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ MPTF_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction
endpackage

/* File: hw/mptf_tx_tagger.sv */
// Inserts the management type and tag after the source address toward the CPU
// and appends a recomputed FCS. Input frames come without FCS, one byte per cycle.
`timescale 1ns/1ps
module mptf_tx_tagger
   import mptf_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic in_valid,
   input wire logic [7:0] in_data,
   input wire logic in_last,
   input wire logic [4:0] in_src_port,
   input wire logic [13:0] in_len,
   output logic in_ready,
   output logic out_valid,
   output logic [7:0] out_data,
   output logic out_last
);
   typedef enum {MPTF_TX_IDLE, MPTF_TX_BODY, MPTF_TX_HDR, MPTF_TX_FCS} mptf_tx_st_t;
   mptf_tx_st_t st_r;
   logic [3:0] cnt_r;
   logic [31:0] crc_r;
   logic [47:0] hdr_r;
   wire [31:0] tag_w = {MPTF_OP_NORMAL, in_len, 10'h000, in_src_port};
   wire [7:0] hdr_byte_w = hdr_r[47:40];
   wire [7:0] fcs_byte_w = ~crc_r[7:0];
   wire [7:0] byte_w = (st_r == MPTF_TX_HDR) ? hdr_byte_w : in_data;

   assign in_ready = (st_r == MPTF_TX_BODY) || (st_r == MPTF_TX_IDLE);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_r <= MPTF_TX_IDLE;
         cnt_r <= 4'h0;
         crc_r <= MPTF_CRC_INIT;
         hdr_r <= 48'h000000000000;
         out_valid <= 1'b0;
         out_data <= 8'h00;
         out_last <= 1'b0;
      end else begin
         out_valid <= 1'b0;
         out_last <= 1'b0;
         unique case (st_r)
            MPTF_TX_IDLE, MPTF_TX_BODY: begin
               if (in_valid) begin
                  out_valid <= 1'b1;
                  out_data <= in_data;
                  crc_r <= mptf_crc_byte((st_r == MPTF_TX_IDLE) ? MPTF_CRC_INIT : crc_r, in_data);
                  cnt_r <= (st_r == MPTF_TX_IDLE) ? 4'h1 : ((cnt_r == 4'hF) ? cnt_r : cnt_r + 4'h1);
                  st_r <= MPTF_TX_BODY;
                  if (cnt_r == 4'(MPTF_SA_END - 1) && st_r == MPTF_TX_BODY) begin
                     hdr_r <= {MPTF_MGMT_TYPE, tag_w};
                     st_r <= MPTF_TX_HDR;
                     cnt_r <= 4'h0;
                  end else if (in_last) begin
                     st_r <= MPTF_TX_FCS;
                     cnt_r <= 4'h0;
                  end
               end
            end
            MPTF_TX_HDR: begin
               out_valid <= 1'b1;
               out_data <= hdr_byte_w;
               crc_r <= mptf_crc_byte(crc_r, byte_w);
               hdr_r <= {hdr_r[39:0], 8'h00};
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r == 4'(MPTF_HDR_BYTES - 1)) begin
                  st_r <= MPTF_TX_BODY;
                  cnt_r <= 4'hF;
               end
            end
            MPTF_TX_FCS: begin
               out_valid <= 1'b1;
               out_data <= fcs_byte_w;
               crc_r <= {8'hFF, crc_r[31:8]};
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r == 4'h3) begin
                  out_last <= 1'b1;
                  st_r <= MPTF_TX_IDLE;
               end
            end
         endcase
      end
   end
endmodule

/* File: hw/mptf_rx_parser.sv */
// Parses host frames: checks the type field, captures the tag, strips the
// header and outer CRC. Result and frame stream are registered.
`timescale 1ns/1ps
module mptf_rx_parser
   import mptf_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic in_valid,
   input wire logic [7:0] in_data,
   input wire logic in_last,
   output logic out_valid,
   output logic [7:0] out_data,
   output logic out_last,
   output logic done,
   output logic drop,
   output logic [31:0] tag
);
   logic [13:0] cnt_r;
   logic [47:0] hdr_r;
   logic [31:0] dly_r;
   wire in_hdr_w = (cnt_r >= 14'(MPTF_SA_END)) && (cnt_r < 14'(MPTF_SA_END + MPTF_HDR_BYTES));
   wire type_ok_w = hdr_r[47:32] == MPTF_MGMT_TYPE;
   wire [2:0] op_w = hdr_r[31:29];
   wire op_ok_w = (op_w == MPTF_OP_NORMAL) || (op_w == MPTF_OP_SINGLE) || (op_w == MPTF_OP_MULTI);
   wire long_w = (cnt_r + 14'h0001) >= MPTF_MIN_HOST_LEN;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt_r <= 14'h0000;
         hdr_r <= 48'h000000000000;
         dly_r <= 32'h00000000;
         out_valid <= 1'b0;
         out_data <= 8'h00;
         out_last <= 1'b0;
         done <= 1'b0;
         drop <= 1'b0;
         tag <= 32'h00000000;
      end else begin
         out_valid <= 1'b0;
         out_last <= 1'b0;
         done <= 1'b0;
         if (in_valid) begin
            cnt_r <= in_last ? 14'h0000 : cnt_r + 14'h0001;
            if (in_hdr_w) begin
               hdr_r <= {hdr_r[39:0], in_data};
            end else begin
               // Four-byte delay holds back the outer CRC so it never leaves
               dly_r <= {dly_r[23:0], in_data};
               out_valid <= cnt_r >= 14'(MPTF_SA_END + MPTF_HDR_BYTES + 4) || cnt_r < 14'(MPTF_SA_END);
               out_data <= (cnt_r < 14'(MPTF_SA_END)) ? in_data : dly_r[31:24];
            end
            if (in_last) begin
               done <= 1'b1;
               out_last <= 1'b1;
               drop <= !(type_ok_w && op_ok_w && long_w);
               tag <= hdr_r[31:0];
            end
         end
      end
   end
endmodule

/* File: testbench/mptf_tb_pkg.sv */
// Bench-side arithmetic for the management tag framer checks.
// Assumes the reflected Ethernet CRC-32, fed one byte at a time.
package mptf_tb_pkg;
   // ==========================================
   // Frame check step, kept apart from the design's own copy
   function automatic logic [31:0] mptf_tb_crc(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {24'h000000, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ 32'hEDB88320) : (r >> 1);
      end
      return r;
   endfunction
endpackage

/* File: testbench/mptf_cpu_model.sv */
// Behavioural management CPU MAC on the far side of the framer.
// Assumes byte-wide streams on sys_clk; it drives on the falling edge.
`timescale 1ns/1ps
module mptf_cpu_model
   import mptf_tb_pkg::*;
(
   input wire logic sys_clk,
   output logic cpu_rx_valid,
   output logic [7:0] cpu_rx_data,
   output logic cpu_rx_last,
   input wire logic cpu_tx_valid,
   input wire logic [7:0] cpu_tx_data,
   input wire logic cpu_tx_last
);
   logic [7:0] rx_q[$];
   int frames;
   initial begin
      cpu_rx_valid = 1'b0;
      cpu_rx_data = 8'hA5;
      cpu_rx_last = 1'b0;
      frames = 0;
   end
   // ==========================================
   // Capture of CPU-bound frames
   always @(posedge sys_clk) begin
      if (cpu_tx_valid) begin
         rx_q.push_back(cpu_tx_data);
         if (cpu_tx_last) begin
            frames++;
         end
      end
   end
   // ==========================================
   // Host frame: addresses, type, tag, payload, outer CRC
   task automatic send_host(input logic [15:0] typ, input logic [31:0] tg, input int len);
      logic [7:0] b[$];
      logic [31:0] c;
      c = 32'hFFFFFFFF;
      for (int i = 0; i < 12; i++) begin
         b.push_back(8'(i + 16));
      end
      b.push_back(typ[15:8]);
      b.push_back(typ[7:0]);
      for (int i = 3; i >= 0; i--) begin
         b.push_back(tg[8*i +: 8]);
      end
      while (b.size() < len - 4) begin
         b.push_back(8'(b.size()));
      end
      foreach (b[i]) begin
         c = mptf_tb_crc(c, b[i]);
      end
      c = ~c;
      for (int i = 0; i < 4; i++) begin
         b.push_back(c[8*i +: 8]);
      end
      foreach (b[i]) begin
         @(negedge sys_clk);
         cpu_rx_valid = 1'b1;
         cpu_rx_data = b[i];
         cpu_rx_last = (i == b.size() - 1);
      end
      @(negedge sys_clk);
      cpu_rx_valid = 1'b0;
      cpu_rx_last = 1'b0;
      // Idle data flips so a stale byte is never mistaken for a live one
      cpu_rx_data = ~cpu_rx_data;
   endtask
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the management tag framer top level.
// Assumes a CPU MAC model on the far side and the switch core driven here.
`timescale 1ns/1ps
module tb_top
   import mptf_pkg::*;
   import mptf_tb_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic sw_valid = 1'b0;
   logic [7:0] sw_data = 8'h00;
   logic sw_last = 1'b0;
   logic sw_first = 1'b0;
   logic [1:0] sw_class = 2'h0;
   logic sw_mirror = 1'b0;
   logic [4:0] sw_src_port = 5'h00;
   logic [13:0] sw_len = 14'h0000;
   logic sw_ready, cpu_tx_valid, cpu_tx_last, cpu_rx_valid, cpu_rx_last;
   logic [7:0] cpu_tx_data, cpu_rx_data, host_data;
   logic [47:0] arl_dest_map = 48'h000000000004;
   logic [16:0] bcast_rule_map = 17'h1FFFE;
   logic host_valid, host_last, host_done, host_drop, port_attached;
   logic [1:0] host_fwd_kind, speed_mode;
   logic [16:0] host_fwd_map;
   int fail_count = 0;
   int cmp_count = 0;
   int hcnt = 0;

   always #25 sys_clk = ~sys_clk;
   // Stripped host bytes: addresses pass, then payload from offset 18 on
   always @(posedge sys_clk) begin
      if (host_valid) begin
         check(host_data, (hcnt < 12) ? hcnt + 16 : hcnt + 6);
         hcnt++;
      end
   end

   mptf_top dut_u (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .sw_valid(sw_valid), .sw_data(sw_data), .sw_last(sw_last), .sw_first(sw_first),
      .sw_class(sw_class), .sw_mirror(sw_mirror), .sw_src_port(sw_src_port),
      .sw_len(sw_len), .sw_ready(sw_ready), .cpu_tx_valid(cpu_tx_valid),
      .cpu_tx_data(cpu_tx_data), .cpu_tx_last(cpu_tx_last), .cpu_rx_valid(cpu_rx_valid),
      .cpu_rx_data(cpu_rx_data), .cpu_rx_last(cpu_rx_last), .arl_dest_map(arl_dest_map),
      .bcast_rule_map(bcast_rule_map), .host_valid(host_valid), .host_data(host_data),
      .host_last(host_last), .host_done(host_done), .host_drop(host_drop),
      .host_fwd_kind(host_fwd_kind), .host_fwd_map(host_fwd_map),
      .speed_mode(speed_mode), .port_attached(port_attached));

   mptf_cpu_model cpu_u (.sys_clk(sys_clk), .cpu_rx_valid(cpu_rx_valid),
      .cpu_rx_data(cpu_rx_data), .cpu_rx_last(cpu_rx_last), .cpu_tx_valid(cpu_tx_valid),
      .cpu_tx_data(cpu_tx_data), .cpu_tx_last(cpu_tx_last));

   // ==========================================
   // Checking and closing
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic give_up();
      fail_count++;
      complete_run();
   endtask
   // ==========================================
   // Register access
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_wr = 1'b0;
   endtask
   task automatic reg_check(input logic [7:0] a, input logic [7:0] e);
      @(negedge sys_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      check(reg_rdata, e);
   endtask
   // ==========================================
   // Switch-core frame and the tagged copy it should yield
   task automatic sw_frame(input logic [1:0] cls, input logic mir, input int n,
                           input logic [4:0] src, input bit on);
      logic [7:0] e[$];
      logic [31:0] c;
      int f0;
      int k;
      f0 = cpu_u.frames;
      cpu_u.rx_q.delete();
      for (int i = 0; i < n; i++) begin
         @(negedge sys_clk);
         sw_valid = 1'b1;
         sw_data = 8'(i + 8'h30);
         sw_first = (i == 0);
         sw_last = (i == n - 1);
         sw_class = cls;
         sw_mirror = mir;
         sw_src_port = src;
         sw_len = 14'(n);
         #1;
         k = 0;
         while (!sw_ready && k < 50) begin
            @(negedge sys_clk);
            #1;
            k++;
         end
         if (k == 50) give_up();
      end
      @(negedge sys_clk);
      sw_valid = 1'b0;
      sw_last = 1'b0;
      k = 0;
      while (cpu_u.frames == f0 && k < 200) begin
         @(negedge sys_clk);
         k++;
      end
      if (!on) begin
         // Nothing may leave for a frame that was not admitted
         check(cpu_u.frames - f0, 0);
      end else begin
         if (k == 200) give_up();
         for (int i = 0; i < 12; i++) e.push_back(8'(i + 8'h30));
         e.push_back(MPTF_MGMT_TYPE[15:8]);
         e.push_back(MPTF_MGMT_TYPE[7:0]);
         c = {3'b000, 14'(n), 10'h000, src};
         for (int i = 3; i >= 0; i--) e.push_back(c[8*i +: 8]);
         for (int i = 12; i < n; i++) e.push_back(8'(i + 8'h30));
         c = 32'hFFFFFFFF;
         foreach (e[i]) c = mptf_tb_crc(c, e[i]);
         c = ~c;
         for (int i = 0; i < 4; i++) e.push_back(c[8*i +: 8]);
         check(cpu_u.rx_q.size(), e.size());
         if (cpu_u.rx_q.size() == e.size()) begin
            foreach (e[i]) check(cpu_u.rx_q[i], e[i]);
         end
      end
   endtask
   // ==========================================
   // Host frame and its steering result
   task automatic host_case(input logic [15:0] typ, input logic [31:0] tg, input int len,
                            input bit bc, input logic drop, input logic [1:0] kind,
                            input logic [16:0] map);
      int k;
      arl_dest_map = bc ? {48{1'b1}} : 48'h000000000004;
      hcnt = 0;
      cpu_u.send_host(typ, tg, len);
      k = 0;
      while (host_done !== 1'b1 && k < 20) begin
         @(negedge sys_clk);
         k++;
      end
      if (k == 20) give_up();
      check(host_drop, drop);
      check(host_last, 1'b1);
      if (!drop) begin
         check(host_fwd_kind, kind);
         if (kind != MPTF_FWD_ARL) check(host_fwd_map, map);
      end
      // The last stripped byte is only counted at the next rising edge
      @(negedge sys_clk);
      if (!drop) check(hcnt, len - 10);
   endtask
   // ==========================================
   // Main sequence
   initial begin
      repeat (3) @(negedge sys_clk);
      rst = 1'b0;
      reg_check(MPTF_ADDR_MGMT_PORT_CONTROL, 8'h00);
      reg_check(MPTF_ADDR_SWITCH_OPERATING_MODE, 8'h00);
      reg_check(MPTF_ADDR_MGMT_CONFIG, 8'h00);
      reg_write(8'h40, 8'hFF);
      reg_check(8'h40, 8'h00);
      reg_write(MPTF_ADDR_MGMT_PORT_CONTROL, 8'h10);
      check(port_attached, 1'b0);
      sw_frame(2'h0, 1'b0, 20, 5'h03, 1'b0);
      reg_write(MPTF_ADDR_SWITCH_OPERATING_MODE, 8'h02);
      reg_write(MPTF_ADDR_MGMT_CONFIG, 8'h81);
      reg_check(MPTF_ADDR_MGMT_PORT_CONTROL, 8'h10);
      reg_check(MPTF_ADDR_SWITCH_OPERATING_MODE, 8'h02);
      reg_check(MPTF_ADDR_MGMT_CONFIG, 8'h81);
      check(port_attached, 1'b1);
      check(speed_mode, 2'h1);
      sw_frame(2'h0, 1'b0, 20, 5'h03, 1'b1);
      sw_frame(2'h1, 1'b0, 20, 5'h04, 1'b0);
      sw_frame(2'h1, 1'b1, 20, 5'h07, 1'b1);
      reg_write(MPTF_ADDR_MGMT_PORT_CONTROL, 8'h08);
      sw_frame(2'h1, 1'b0, 20, 5'h01, 1'b1);
      sw_frame(2'h0, 1'b0, 20, 5'h02, 1'b0);
      reg_write(MPTF_ADDR_MGMT_PORT_CONTROL, 8'h04);
      sw_frame(2'h2, 1'b0, 64, 5'h10, 1'b1);
      reg_check(MPTF_ADDR_STATUS, 8'h04);
      host_case(16'h8874, 32'h00000000, 74, 0, 1'b0, MPTF_FWD_ARL, 17'h0);
      host_case(16'h8874, 32'h00000000, 74, 1, 1'b0, MPTF_FWD_BCAST, 17'h1FFFE);
      host_case(16'h8874, 32'h40000FE5, 74, 0, 1'b0, MPTF_FWD_MAP, 17'h00020);
      host_case(16'h8874, 32'h60010003, 74, 0, 1'b0, MPTF_FWD_MAP, 17'h10003);
      host_case(16'h8874, 32'h20000005, 74, 0, 1'b1, MPTF_FWD_ARL, 17'h0);
      host_case(16'h8874, 32'h80000005, 74, 0, 1'b1, MPTF_FWD_ARL, 17'h0);
      host_case(16'h8874, 32'hE0000005, 74, 0, 1'b1, MPTF_FWD_ARL, 17'h0);
      host_case(16'h8100, 32'h00000000, 74, 0, 1'b1, MPTF_FWD_ARL, 17'h0);
      host_case(16'h8874, 32'h00000000, 73, 0, 1'b1, MPTF_FWD_ARL, 17'h0);
      complete_run();
   end
endmodule
